//--- logic/sac_regs.svh
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
// Word width and power-up word
`define SAC_WORD_W 7
`define SAC_WORD_MAX 7'h7F
`define SAC_WORD_ZERO 7'h00
// Host timing, in ns, and derived counts at the 20 ns core clock
`define SAC_CLK_NS 20
`define SAC_MODE_SETUP_NS 100
`define SAC_LE_DELAY_NS 10
`define SAC_LE_WIDTH_NS 10
`define SAC_MODE_SETUP_CYC ((`SAC_MODE_SETUP_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_LE_DELAY_CYC ((`SAC_LE_DELAY_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_LE_WIDTH_CYC ((`SAC_LE_WIDTH_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
// Serial clock divider: half period minus one, in core cycles
`define SAC_SCLK_HALF 4'h4
`define SAC_CNT_W 4
`define SAC_BIT_LAST 3'h6
`endif

//--- logic/sac_pkg.sv
`default_nettype none
`include "sac_regs.svh"
package sac_pkg;
    typedef logic [`SAC_WORD_W-1:0] sac_word_t;
    typedef enum logic {SAC_MODE_PARALLEL, SAC_MODE_SERIAL} sac_mode_t;
endpackage
`default_nettype wire

//--- logic/sac_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sac_link_if;
    import sac_pkg::*;
    logic mode_sel;
    logic mode_sel_oe_n;
    logic latch_strobe;
    logic sclk;
    logic sdata;
    sac_word_t weights;
    // Unconnected mode pin floats to serial
    wire mode_level = mode_sel_oe_n ? 1'b1 : mode_sel;
    modport host (output mode_sel, output mode_sel_oe_n, output latch_strobe,
        output sclk, output sdata, output weights);
    modport device (input mode_level, input latch_strobe, input sclk, input sdata,
        input weights);
endinterface
`default_nettype wire

//--- logic/sac_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sac_sync
    import sac_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_val,
    output logic [WIDTH-1:0] clean_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] clean_reg;
    logic [2:0] fill_reg;
    wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
    // ---------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // Reset value holds until all three stages carry the real pin level,
    // so the reset zeros in the stages never count as an agreed change
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_reg <= '0;
        end else begin
            fill_reg <= {fill_reg[1:0], 1'b1};
        end
    end
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (!fill_reg[2]) begin
                    clean_reg[i] <= reset_val[i];
                end else if (agree[i]) begin
                    clean_reg[i] <= s3_reg[i];
                end
            end
        end
    endgenerate
    assign clean_out = clean_reg;
endmodule
`default_nettype wire

//--- logic/sac_device.sv
`timescale 1ns/1ps
`default_nettype none
module sac_device
    import sac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    sac_link_if.device link,
    output logic [`SAC_WORD_W-1:0] atten_word,
    output logic serial_mode
);
    // ---------------------------------------------------------------
    // Input synchronisers: mode, strobe, clock, data, then weights
    // ---------------------------------------------------------------
    localparam int NSYNC = `SAC_WORD_W + 4;
    logic [NSYNC-1:0] pins_clean;
    sac_sync #(.WIDTH(NSYNC)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({link.mode_level, link.latch_strobe, link.sclk, link.sdata, link.weights}),
        .reset_val({1'b1, 1'b1, 1'b0, 1'b0, `SAC_WORD_ZERO}),
        .clean_out(pins_clean)
    );
    wire mode_serial = pins_clean[NSYNC-1];
    wire strobe = pins_clean[NSYNC-2];
    wire sclk = pins_clean[NSYNC-3];
    wire sdata = pins_clean[NSYNC-4];
    wire [`SAC_WORD_W-1:0] par_bits = pins_clean[`SAC_WORD_W-1:0];
    logic strobe_d_reg;
    logic sclk_d_reg;
    logic [`SAC_WORD_W-1:0] shift_reg;
    logic [`SAC_WORD_W-1:0] shift_next;
    logic [`SAC_WORD_W-1:0] active_reg;
    logic [`SAC_WORD_W-1:0] active_next;
    logic mode_reg;
    // Edge detection on the cleaned strobe and serial clock
    wire strobe_rise = strobe & ~strobe_d_reg;
    wire sclk_rise = sclk & ~sclk_d_reg & ~strobe;
    // First bit in drifts down to bit 0; extra bits push the oldest out
    assign shift_next = sclk_rise ? {sdata, shift_reg[`SAC_WORD_W-1:1]} : shift_reg;
    // Active word selection; held value otherwise, so bit changes with the strobe low are ignored
    wire direct_par = ~mode_serial & strobe & ~strobe_rise;
    wire [`SAC_WORD_W-1:0] latch_src = mode_serial ? shift_reg : par_bits;
    assign active_next = strobe_rise ? latch_src : (direct_par ? par_bits : active_reg);
    // ---------------------------------------------------------------
    // State registers
    // ---------------------------------------------------------------
    // Edge history starts high so a strobe held high at power-up is no edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_d_reg <= 1'b1;
            sclk_d_reg <= 1'b1;
            mode_reg <= 1'b1;
        end else begin
            strobe_d_reg <= strobe;
            sclk_d_reg <= sclk;
            mode_reg <= mode_serial;
        end
    end
    // Power-up is maximum attenuation, except in parallel mode with the strobe high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= `SAC_WORD_MAX;
            active_reg <= `SAC_WORD_MAX;
        end else begin
            shift_reg <= shift_next;
            active_reg <= active_next;
        end
    end
    // Bit n carries 0.25 dB times two to the n; a one steps it in
    assign atten_word = active_reg;
    assign serial_mode = mode_reg;
endmodule
`default_nettype wire

//--- logic/sac_host.sv
`timescale 1ns/1ps
`default_nettype none
module sac_host
    import sac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    sac_link_if.host link,
    input wire logic req_valid,
    input wire logic req_serial,
    input wire logic req_direct,
    input wire logic [`SAC_WORD_W-1:0] req_word,
    output logic req_ready,
    output logic done
);
    typedef enum logic [2:0] {SAC_IDLE, SAC_SETUP, SAC_STROBE_LOW, SAC_SHIFT, SAC_GAP,
        SAC_STROBE_HIGH} sac_hstate_t;
    sac_hstate_t state_reg;
    logic [`SAC_CNT_W-1:0] cnt_reg;
    logic [2:0] bit_reg;
    logic [`SAC_WORD_W-1:0] word_reg;
    logic serial_reg;
    logic direct_reg;
    logic mode_reg;
    logic strobe_reg;
    logic sclk_reg;
    logic sdata_reg;
    logic [`SAC_WORD_W-1:0] par_reg;
    logic ready_reg;
    logic done_reg;
    // Slow serial clock phase: each phase lasts SAC_SCLK_HALF + 1 core cycles
    wire tick = (cnt_reg == '0);
    wire mode_change = (serial_reg != mode_reg);
    // ---------------------------------------------------------------
    // Sequencer; strobe idles high and every hold rounds up to cycles
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SAC_IDLE;
            cnt_reg <= '0;
            bit_reg <= '0;
            word_reg <= '0;
            serial_reg <= 1'b1;
            direct_reg <= 1'b0;
            mode_reg <= 1'b1;
            strobe_reg <= 1'b1;
            sclk_reg <= 1'b0;
            sdata_reg <= 1'b0;
            par_reg <= '0;
            ready_reg <= 1'b1;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            unique case (state_reg)
                SAC_IDLE: begin
                    if (req_valid) begin
                        ready_reg <= 1'b0;
                        word_reg <= req_word;
                        serial_reg <= req_serial;
                        direct_reg <= req_direct & ~req_serial;
                        state_reg <= SAC_SETUP;
                        cnt_reg <= `SAC_CNT_W'(`SAC_MODE_SETUP_CYC);
                    end
                end
                SAC_SETUP: begin
                    // Drive the new mode, then wait the setup time
                    mode_reg <= serial_reg;
                    if (mode_change) begin
                        cnt_reg <= `SAC_CNT_W'(`SAC_MODE_SETUP_CYC);
                    end else if (tick) begin
                        if (direct_reg) begin
                            par_reg <= word_reg;
                            state_reg <= SAC_GAP;
                            cnt_reg <= `SAC_SCLK_HALF;
                        end else begin
                            strobe_reg <= 1'b0;
                            par_reg <= word_reg;
                            state_reg <= serial_reg ? SAC_STROBE_LOW : SAC_GAP;
                            cnt_reg <= `SAC_SCLK_HALF;
                        end
                    end
                end
                SAC_STROBE_LOW: begin
                    if (tick) begin
                        sdata_reg <= word_reg[0];
                        word_reg <= {1'b0, word_reg[`SAC_WORD_W-1:1]};
                        bit_reg <= '0;
                        state_reg <= SAC_SHIFT;
                        cnt_reg <= `SAC_SCLK_HALF;
                    end
                end
                SAC_SHIFT: begin
                    if (tick) begin
                        sclk_reg <= ~sclk_reg;
                        cnt_reg <= `SAC_SCLK_HALF;
                        // Leave on the last fall so the last high phase is full width
                        if (sclk_reg) begin
                            if (bit_reg == `SAC_BIT_LAST) begin
                                state_reg <= SAC_GAP;
                            end else begin
                                sdata_reg <= word_reg[0];
                                word_reg <= {1'b0, word_reg[`SAC_WORD_W-1:1]};
                                bit_reg <= bit_reg + 3'h1;
                            end
                        end
                    end
                end
                SAC_GAP: begin
                    // Clock falls, then strobe rises well after the last rise
                    sclk_reg <= 1'b0;
                    if (tick) begin
                        strobe_reg <= 1'b1;
                        state_reg <= SAC_STROBE_HIGH;
                        cnt_reg <= `SAC_CNT_W'(`SAC_LE_WIDTH_CYC + `SAC_LE_DELAY_CYC);
                    end
                end
                SAC_STROBE_HIGH: begin
                    if (tick) begin
                        done_reg <= 1'b1;
                        ready_reg <= 1'b1;
                        state_reg <= SAC_IDLE;
                    end
                end
            endcase
        end
    end
    // Mode pin is driven always; the device would read an open pin as serial
    assign link.mode_sel = mode_reg;
    assign link.mode_sel_oe_n = 1'b0;
    assign link.latch_strobe = strobe_reg;
    assign link.sclk = sclk_reg;
    assign link.sdata = sdata_reg;
    assign link.weights = par_reg;
    assign req_ready = ready_reg;
    assign done = done_reg;
endmodule
`default_nettype wire

//--- tb/sac_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sac_link_asserts
    import sac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic mode_sel,
    input wire logic mode_sel_oe_n,
    input wire logic mode_level,
    input wire logic latch_strobe,
    input wire logic sclk,
    input wire logic sdata,
    input wire sac_word_t weights
);
    // ----------------
    // Helper logic
    // ----------------
    logic sclk_q;
    logic [3:0] rise_cnt;
    // Rises per frame; cleared while the strobe idles high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            rise_cnt <= 4'h0;
        end else begin
            sclk_q <= sclk;
            rise_cnt <= latch_strobe ? 4'h0 : rise_cnt + {3'h0, sclk & ~sclk_q};
        end
    end
    // ----------------
    // Link properties
    // ----------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_strobe_low2;
        !latch_strobe ##1 !latch_strobe;
    endsequence
    sequence s_strobe_rise;
        $rose(latch_strobe);
    endsequence
    property p_mode_driven;
        !mode_sel_oe_n && mode_level == mode_sel;
    endproperty
    property p_clk_idle;
        latch_strobe |-> !sclk;
    endproperty
    property p_le_delay;
        sclk |-> s_strobe_low2;
    endproperty
    property p_serial_setup;
        $fell(latch_strobe) && mode_level |-> $past(mode_level, 4);
    endproperty
    property p_par_setup;
        $fell(latch_strobe) && !mode_level |-> !$past(mode_level, 4);
    endproperty
    property p_width;
        $changed(latch_strobe) |=> $stable(latch_strobe);
    endproperty
    property p_hold;
        $changed(sdata) |-> !sclk;
    endproperty
    property p_seven;
        s_strobe_rise ##0 mode_level |-> rise_cnt == 4'h7;
    endproperty
    property p_par_quiet;
        !mode_level |-> !sclk;
    endproperty
    property p_par_stable;
        s_strobe_rise ##0 !mode_level |-> $stable(weights);
    endproperty
    a_mode_driven: assert property (p_mode_driven) else $error("mode pin floats");
    a_clk_idle: assert property (p_clk_idle) else $error("clock with strobe high");
    a_le_delay: assert property (p_le_delay) else $error("strobe too early");
    a_serial_setup: assert property (p_serial_setup) else $error("serial setup");
    a_par_setup: assert property (p_par_setup) else $error("parallel setup");
    a_width: assert property (p_width) else $error("strobe pulse short");
    a_hold: assert property (p_hold) else $error("data moved in clock high");
    a_seven: assert property (p_seven) else $error("frame not seven bits");
    a_par_quiet: assert property (p_par_quiet) else $error("clock in parallel");
    a_par_stable: assert property (p_par_stable) else $error("weights moved");
endmodule
`default_nettype wire

//--- tb/step_attenuator_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module step_attenuator_control_test;
    logic core_clk, rst_n, req_valid, req_serial, req_direct, done, req_ready;
    logic serial_mode, serial_mode2;
    logic [6:0] req_word, atten_word, atten_word2;
    int n_fail, n_tests;
    // -----------------
    // Two links: host to device, bench to device
    // -----------------
    sac_link_if link();
    sac_link_if link2();
    sac_host sac_host_i(.core_clk(core_clk), .rst_n(rst_n), .link(link),
        .req_valid(req_valid), .req_serial(req_serial), .req_direct(req_direct),
        .req_word(req_word), .req_ready(req_ready), .done(done));
    sac_device sac_device_i(.core_clk(core_clk), .rst_n(rst_n), .link(link),
        .atten_word(atten_word), .serial_mode(serial_mode));
    // Second device lets the bench break host habits on purpose
    sac_device sac_device_i2(.core_clk(core_clk), .rst_n(rst_n), .link(link2),
        .atten_word(atten_word2), .serial_mode(serial_mode2));
    sac_link_asserts sac_link_asserts_i(.core_clk(core_clk), .rst_n(rst_n),
        .mode_sel(link.mode_sel), .mode_sel_oe_n(link.mode_sel_oe_n),
        .mode_level(link.mode_level), .latch_strobe(link.latch_strobe),
        .sclk(link.sclk), .sdata(link.sdata), .weights(link.weights));
    // -----------------
    // Shared tasks
    // -----------------
    task end_sim;
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task check(input logic [6:0] seen, input logic [6:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // One host request; the bound cuts a hung handshake short
    task host_req(input logic ser, input logic dir, input logic [6:0] w);
        int i;
        req_serial = ser;
        req_direct = dir;
        req_word = w;
        req_valid = 1'b1;
        tick(1);
        req_valid = 1'b0;
        i = 0;
        while (done !== 1'b1 && i < 300) begin
            @(posedge core_clk);
            #1;
            i++;
        end
        if (done !== 1'b1) begin
            n_fail++;
            end_sim;
        end
        // Host is ready again and idles with the strobe high
        check({5'h00, req_ready, link.latch_strobe}, 7'h03);
        tick(8);
    endtask
    // Bench frame at 160 ns per bit; data moves only with the clock low
    task b_shift(input logic [8:0] v, input int n);
        for (int k = 0; k < n; k++) begin
            link2.sdata = v[k];
            tick(4);
            link2.sclk = 1'b1;
            tick(4);
            link2.sclk = 1'b0;
        end
        link2.sdata = ~v[n-1];
        tick(4);
    endtask
    // -----------------
    // Scenarios
    // -----------------
    task t_power_up;
        check(atten_word, 7'h7F);
        check({6'h00, serial_mode}, 7'h01);
        check(atten_word2, 7'h7F);
    endtask
    task t_serial;
        logic [6:0] w [3] = '{7'h01, 7'h40, 7'h2B};
        for (int k = 0; k < 3; k++) begin
            host_req(1'b1, 1'b0, w[k]);
            check(atten_word, w[k]);
        end
    endtask
    task t_parallel;
        host_req(1'b0, 1'b1, 7'h15);
        check(atten_word, 7'h15);
        check({6'h00, serial_mode}, 7'h00);
        host_req(1'b0, 1'b0, 7'h6A);
        check(atten_word, 7'h6A);
        host_req(1'b1, 1'b0, 7'h33);
        check(atten_word, 7'h33);
    endtask
    // Strobe pulses stay eight cycles wide or more
    task t_dev2_latched;
        link2.weights = 7'h2A;
        tick(10);
        check(atten_word2, 7'h7F);
        link2.latch_strobe = 1'b1;
        tick(8);
        check(atten_word2, 7'h2A);
        link2.weights = 7'h13;
        tick(8);
        check(atten_word2, 7'h13);
        link2.latch_strobe = 1'b0;
        tick(8);
        link2.weights = 7'h64;
        tick(8);
        check(atten_word2, 7'h13);
    endtask
    // Nine bits keep the last seven; clocks under a high strobe are lost
    task t_dev2_serial;
        logic [8:0] v;
        v = 9'h1A5;
        link2.mode_sel_oe_n = 1'b1;
        tick(10);
        check({6'h00, serial_mode2}, 7'h01);
        b_shift(v, 9);
        link2.latch_strobe = 1'b1;
        tick(8);
        check(atten_word2, v[8:2]);
        b_shift(9'h1FF, 7);
        check(atten_word2, v[8:2]);
        link2.latch_strobe = 1'b0;
        tick(8);
        link2.latch_strobe = 1'b1;
        tick(8);
        check(atten_word2, v[8:2]);
    endtask
    // -----------------
    // Clock and main sequence
    // -----------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_serial = 1'b0;
        req_direct = 1'b0;
        req_word = 7'h00;
        link2.mode_sel = 1'b0;
        link2.mode_sel_oe_n = 1'b0;
        link2.latch_strobe = 1'b0;
        link2.sclk = 1'b0;
        link2.sdata = 1'b0;
        link2.weights = 7'h00;
        n_fail = 0;
        n_tests = 0;
        repeat (6) @(posedge core_clk);
        tick(1);
        rst_n = 1'b1;
        tick(10);
        t_power_up;
        t_serial;
        t_parallel;
        t_dev2_latched;
        t_dev2_serial;
        end_sim;
    end
endmodule
`default_nettype wire
